// File: logic/hot_swap_consts.vh
// Constants for the hot-swap control and status register.
// Assumes inclusion by the register module only; definitions only.
`ifndef HOT_SWAP_CONSTS_VH
`define HOT_SWAP_CONSTS_VH

// ----------------------------------------------------------------
// Register location
// ----------------------------------------------------------------
`define HS_CSR_OFFSET       8'hE4
`define HS_CSR_LANE         2
`define HS_CSR_RESET        8'h00

// ----------------------------------------------------------------
// Field positions within the byte (bits 23:16 of the dword)
// ----------------------------------------------------------------
`define HS_BIT_INSERTED     7
`define HS_BIT_REMOVAL      6
`define HS_BIT_LAMP         3
`define HS_BIT_MASK         1

// ----------------------------------------------------------------
// Input filtering
// ----------------------------------------------------------------
`define HS_SYNC_STAGES      3

`endif

// File: logic/pin_sync.v
// Three-stage synchroniser for a pin from outside the clock domain.
// Assumes sys_clk is the only clock; output changes once stages two and three agree.
`timescale 1ns/100ps

module pin_sync (
    input  wire sys_clk,
    input  wire reset,
    input  wire pin_in,
    output reg  level_ff
);

    reg [2:0] stage_ff;

    // Stage one feeds only stage two; stages two and three vote
    always @(posedge sys_clk) begin
        if (reset) begin
            stage_ff <= 3'h0;
            level_ff <= 1'b0;
        end else begin
            stage_ff <= {stage_ff[1:0], pin_in};
            if (stage_ff[1] == stage_ff[2]) begin
                level_ff <= stage_ff[2];
            end
        end
    end

endmodule

// File: logic/hot_swap_control_status.v
// Hot-swap control and status byte of the bridge configuration space.
// Assumes a simple configuration access port on the primary clock: one-cycle
// read and write strobes, dword offset and per-byte enables.
`timescale 1ns/100ps
`include "hot_swap_consts.vh"

// Summary of operation
// - Inserted flag sets after handle closed and bus reset released; write one clears.
// - Inserted flag set asserts active-low enumeration output unless masked.
// - Removal flag set on imminent extraction, then enumeration asserted; write one clears.
// - Lamp pin lit while lamp bit is one; bit resets to zero.
// - Mask bit one stops driving enumeration; zero allows it; resets zero.
// - Bits 21:20, 18 and 16 read zero; writes ignored.
// - Bit 18 is read-only zero, no interrupt enable there.
module hot_swap_control_status (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    input  wire        handle_closed,
    input  wire        removal_request,
    output reg         enum_n_out,
    output reg         enum_n_oe,
    output reg         indicator_lamp_on
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire handle_sync;
    wire removal_sync;

    pin_sync u_handle_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .pin_in   (handle_closed),
        .level_ff (handle_sync)
    );

    pin_sync u_removal_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .pin_in   (removal_request),
        .level_ff (removal_sync)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg        board_inserted_flag_ff;
    reg        board_removal_flag_ff;
    reg        lamp_bit_ff;
    reg        enumeration_out_mask_ff;
    reg        handle_prev_ff;
    reg        removal_prev_ff;

    // Next values, each group worked out in its own combinational block
    reg        nxt_board_inserted_flag;
    reg        nxt_board_removal_flag;
    reg        nxt_lamp_bit;
    reg        nxt_enumeration_out_mask;
    reg [31:0] nxt_cfg_rdata;
    reg        nxt_enum_n_oe;
    reg        nxt_indicator_lamp_on;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire       hit;
    wire       byte_wr;
    wire       byte_rd;
    wire [7:0] wbyte;
    wire       clear_inserted;
    wire       clear_removal;

    // Only the full dword offset selects us; lane 2 carries our byte
    assign hit     = (cfg_addr == `HS_CSR_OFFSET);
    assign byte_wr = cfg_wr & hit & cfg_be[`HS_CSR_LANE];
    assign byte_rd = cfg_rd & hit;
    assign wbyte   = cfg_wdata[23:16];

    // A one written to a flag clears it; a zero leaves it alone
    assign clear_inserted = byte_wr & wbyte[`HS_BIT_INSERTED];
    assign clear_removal  = byte_wr & wbyte[`HS_BIT_REMOVAL];

    // ------------------------------------------------------------
    // Pin events
    // ------------------------------------------------------------
    wire insert_evt;
    wire removal_evt;

    // Events: rising edge of a filtered pin. Reset is synchronous, so the
    // handle edge can only be seen once the bus reset has gone away.
    assign insert_evt  = handle_sync & ~handle_prev_ff;
    assign removal_evt = removal_sync & ~removal_prev_ff;

    // Edge history starts low, the idle level of both pins, so no false edge
    always @(posedge sys_clk) begin
        if (reset) begin
            handle_prev_ff  <= 1'b0;
            removal_prev_ff <= 1'b0;
        end else begin
            handle_prev_ff  <= handle_sync;
            removal_prev_ff <= removal_sync;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // insertion and removal set, W1C
    always @* begin
        nxt_board_inserted_flag = board_inserted_flag_ff;
        nxt_board_removal_flag  = board_removal_flag_ff;
        // A set in the clearing cycle wins, so no event is ever lost
        if (insert_evt) begin
            nxt_board_inserted_flag = 1'b1;
        end else if (clear_inserted) begin
            nxt_board_inserted_flag = 1'b0;
        end
        if (removal_evt) begin
            nxt_board_removal_flag = 1'b1;
        end else if (clear_removal) begin
            nxt_board_removal_flag = 1'b0;
        end
    end

    // Flag registers
    always @(posedge sys_clk) begin
        if (reset) begin
            board_inserted_flag_ff <= 1'b0;
            board_removal_flag_ff  <= 1'b0;
        end else begin
            board_inserted_flag_ff <= nxt_board_inserted_flag;
            board_removal_flag_ff  <= nxt_board_removal_flag;
        end
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    // lamp and mask control bits
    always @* begin
        nxt_lamp_bit             = lamp_bit_ff;
        nxt_enumeration_out_mask = enumeration_out_mask_ff;
        // Plain read/write bits; a write without lane 2 leaves them as they are
        if (byte_wr) begin
            nxt_lamp_bit             = wbyte[`HS_BIT_LAMP];
            nxt_enumeration_out_mask = wbyte[`HS_BIT_MASK];
        end
    end

    // Control registers, both zero after reset
    always @(posedge sys_clk) begin
        if (reset) begin
            lamp_bit_ff             <= 1'b0;
            enumeration_out_mask_ff <= 1'b0;
        end else begin
            lamp_bit_ff             <= nxt_lamp_bit;
            enumeration_out_mask_ff <= nxt_enumeration_out_mask;
        end
    end

    // ------------------------------------------------------------
    // Read data and pins
    // ------------------------------------------------------------
    reg  [7:0] status_byte;
    wire       enum_drive;

    always @* begin
        status_byte                   = 8'h00;
        status_byte[`HS_BIT_INSERTED] = board_inserted_flag_ff;
        status_byte[`HS_BIT_REMOVAL]  = board_removal_flag_ff;
        status_byte[`HS_BIT_LAMP]     = lamp_bit_ff;
        status_byte[`HS_BIT_MASK]     = enumeration_out_mask_ff;
    end

    // Either flag requests enumeration; the mask wins over both
    assign enum_drive = (board_inserted_flag_ff | board_removal_flag_ff)
                        & ~enumeration_out_mask_ff;

    // Output next values; read data holds until the next read strobe
    always @* begin
        nxt_cfg_rdata = cfg_rdata;
        if (byte_rd) begin
            nxt_cfg_rdata = {8'h00, status_byte, 16'h0000};
        end else if (cfg_rd) begin
            nxt_cfg_rdata = 32'h0000_0000;  // Unmapped offsets read zero
        end
        nxt_enum_n_oe         = enum_drive;
        nxt_indicator_lamp_on = lamp_bit_ff;
    end

    // Outputs registered; open drain, so data stays low and only the enable
    // moves. The host sees the line one cycle after the flag changes.
    always @(posedge sys_clk) begin
        if (reset) begin
            cfg_rdata         <= 32'h0000_0000;
            enum_n_out        <= 1'b0;
            enum_n_oe         <= 1'b0;
            indicator_lamp_on <= 1'b0;
        end else begin
            cfg_rdata         <= nxt_cfg_rdata;
            enum_n_out        <= 1'b0;
            enum_n_oe         <= nxt_enum_n_oe;
            indicator_lamp_on <= nxt_indicator_lamp_on;
        end
    end

endmodule

// File: verification/enum_line_model.sv
// Host-side view of the open-drain enumeration line.
// Assumes a pull-up on the line and the block as its only driver.
`timescale 1ns/100ps
module enum_line_model (
    input  wire enum_n_out,
    input  wire enum_n_oe,
    output wire enum_line
);
    assign enum_line = enum_n_oe ? enum_n_out : 1'b1;
endmodule

// File: verification/hot_swap_sva.sv
// Port checker for the hot-swap register, bound to the block.
`timescale 1ns/100ps
module hot_swap_sva (
    input wire        sys_clk, reset, cfg_wr, cfg_rd,
    input wire [7:0]  cfg_addr,
    input wire [3:0]  cfg_be,
    input wire [31:0] cfg_wdata, cfg_rdata,
    input wire        handle_closed, removal_request, enum_n_out, enum_n_oe, indicator_lamp_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire hit = cfg_wr && cfg_addr == 8'hE4 && cfg_be[2];
    reg  lamp_ff, mask_ff;
    // Shadow of the writable bits, since only ports are visible here
    always @(posedge sys_clk) begin
        lamp_ff <= reset ? 1'b0 : hit ? cfg_wdata[19] : lamp_ff;
        mask_ff <= reset ? 1'b0 : hit ? cfg_wdata[17] : mask_ff;
    end
    od_data_a: assert property (!enum_n_out) else $error("enum data high");
    lamp_match_a: assert property (
        indicator_lamp_on == $past(lamp_ff)) else $error("lamp wrong");
    mask_gate_a: assert property (
        enum_n_oe |-> !$past(mask_ff)) else $error("enum while masked");
    rd_fields_a: assert property (
        cfg_rd && cfg_addr == 8'hE4 |=> cfg_rdata[21:16] ==
        {2'b00, $past(lamp_ff), 1'b0, $past(mask_ff), 1'b0}) else $error("read fields");
    unmapped_rd_a: assert property (
        cfg_rd && cfg_addr != 8'hE4 |=> cfg_rdata == 32'h0) else $error("unmapped read");
    insert_enum_a: assert property (
        $rose(handle_closed) && !mask_ff |-> ##[3:8] enum_n_oe) else $error("no insert enum");
    remove_enum_a: assert property (
        $rose(removal_request) && !mask_ff |-> ##[3:8] enum_n_oe) else $error("no remove enum");
    clear_release_a: assert property (
        hit && cfg_wdata[23:22] == 2'b11 && !handle_closed && !removal_request
        |=> ##1 !enum_n_oe) else $error("enum not released");
    cover property ($rose(enum_n_oe));
    cover property ($fell(enum_n_oe));
    cover property (hit && cfg_wdata[17]);
endmodule
bind hot_swap_control_status hot_swap_sva i_hot_swap_sva (.sys_clk, .reset, .cfg_wr,
    .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .handle_closed, .removal_request,
    .enum_n_out, .enum_n_oe, .indicator_lamp_on);

// File: verification/hot_swap_control_status_tb_top.sv
// Bench: config access tasks, pin stimulus, lamp and enumeration line checks.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module hot_swap_control_status_tb_top;
    logic        sys_clk = 0, reset = 1, cfg_wr = 0, cfg_rd = 0;
    logic        handle_closed = 0, removal_request = 0;
    logic [7:0]  cfg_addr = 8'hE4;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    wire  [31:0] cfg_rdata;
    wire         enum_n_out, enum_n_oe, indicator_lamp_on, enum_line;
    int          err_count = 0, comparisons = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    hot_swap_control_status i_hot_swap_control_status (.sys_clk, .reset, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .handle_closed, .removal_request,
        .enum_n_out, .enum_n_oe, .indicator_lamp_on);
    enum_line_model i_enum_line_model (.enum_n_out, .enum_n_oe, .enum_line);
    // Inputs move 1 ns after an edge so no race with sampling
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_addr = a; cfg_be = be; cfg_wdata = d; cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
    endtask
    // Only lane 2 is ours; the checker covers the other lanes only for reads of unmapped offsets
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cfg_addr = a; cfg_rd = 1'b1;
        tick(1);
        cfg_rd = 1'b0;
        `CHK("rdata", e, cfg_rdata[23:16])
        tick(1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Whole run needs about 70 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin err_count++; wrap_up(); end
    end
    initial begin
        tick(3);
        reset = 1'b0;
        tick(1);
        rd(8'hE4, 8'h00);
        wr(8'hE4, 4'hF, 32'hFFFFFFFF);
        rd(8'hE4, 8'h0A);
        tick(1);
        `CHK("lamp", 1'b1, indicator_lamp_on)
        wr(8'hE4, 4'hB, 32'h0);
        wr(8'hE0, 4'hF, 32'h0);
        rd(8'hE0, 8'h00);
        rd(8'hE4, 8'h0A);
        wr(8'hE4, 4'h4, 32'h0);
        handle_closed = 1'b1;
        tick(8);
        rd(8'hE4, 8'h80);
        `CHK("enum", 1'b0, enum_line)
        `CHK("lamp", 1'b0, indicator_lamp_on)
        wr(8'hE4, 4'h4, 32'h00020000);
        tick(2);
        `CHK("enum", 1'b1, enum_line)
        wr(8'hE4, 4'h4, 32'h0);
        tick(2);
        `CHK("enum", 1'b0, enum_line)
        handle_closed = 1'b0;
        removal_request = 1'b1;
        tick(8);
        rd(8'hE4, 8'hC0);
        removal_request = 1'b0;
        tick(8);
        wr(8'hE4, 4'h4, 32'h00800000);
        rd(8'hE4, 8'h40);
        `CHK("enum", 1'b0, enum_line)
        wr(8'hE4, 4'h4, 32'h00C00000);
        tick(2);
        `CHK("enum", 1'b1, enum_line)
        rd(8'hE4, 8'h00);
        wrap_up();
    end
endmodule
